// ==== verilog/sfpcs_pkg.sv ====
package sfpcs_pkg;
  localparam int CSR_W    = 32;
  localparam int NUM_EXC  = 6;
  localparam int FLAG_LO  = 0;
  localparam int DAZ_BIT  = 6;
  localparam int MASK_LO  = 7;
  localparam int RC_LO    = 13;
  localparam int RC_W     = 2;
  localparam int FZ_BIT   = 15;
  localparam int RSV_LO   = 16;
  localparam int RSV_W    = 16;
  // exception order shared by flags and masks
  localparam int EXC_IE   = 0;
  localparam int EXC_DE   = 1;
  localparam int EXC_ZE   = 2;
  localparam int EXC_OE   = 3;
  localparam int EXC_UE   = 4;
  localparam int EXC_PE   = 5;
  localparam logic [CSR_W-1:0] CSR_RESET   = 32'h0000_1f80;
  localparam logic [CSR_W-1:0] MASK_FULL   = 32'h0000_ffff;
  localparam logic [CSR_W-1:0] DAZ_BIT_VAL = 32'h0000_0040;
  // packed operand layout
  localparam int VEC_W     = 128;
  localparam int LANE_W    = 32;
  localparam int LANES     = 4;
  localparam int SIGN_BIT  = 31;
  localparam int EXP_LO    = 23;
  localparam int EXP_W     = 8;
  localparam int MANT_W    = 23;
  localparam int NUM_VREGS = 8;
  localparam int ALIGN_LSB = 4;
  localparam int ADDR_W    = 32;
  typedef enum logic [1:0] {
    RC_NEAREST = 2'b00,
    RC_DOWN    = 2'b01,
    RC_UP      = 2'b10,
    RC_ZERO    = 2'b11
  } sfpcs_rc_t;
  typedef enum logic [1:0] {
    MK_PACKED    = 2'b00,
    MK_UNALIGNED = 2'b01,
    MK_SCALAR    = 2'b10,
    MK_NONE      = 2'b11
  } sfpcs_mkind_t;
endpackage

// ==== verilog/sfpcs_lane_zero.sv ====
`timescale 1ns/1ps
module sfpcs_lane_zero
  import sfpcs_pkg::*;
#(
  parameter int N_LANES = LANES
) (
  input  wire logic [N_LANES*LANE_W-1:0] data_in,
  input  wire logic [N_LANES-1:0]        zero_sel,
  output logic      [N_LANES*LANE_W-1:0] data_out,
  output logic      [N_LANES-1:0]        denorm
);
  genvar g;
  generate
    for (g = 0; g < N_LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane;
      assign lane = data_in[g*LANE_W +: LANE_W];
      // zero exponent with nonzero fraction
      assign denorm[g] = (lane[EXP_LO +: EXP_W] == '0) && (lane[0 +: MANT_W] != '0);
      // signed zero keeps the original sign
      assign data_out[g*LANE_W +: LANE_W] =
        zero_sel[g] ? {lane[SIGN_BIT], {(LANE_W-1){1'b0}}} : lane;
    end
  endgenerate
endmodule // sfpcs_lane_zero

// ==== verilog/sfpcs_vreg_mem.sv ====
`timescale 1ns/1ps
module sfpcs_vreg_mem
  import sfpcs_pkg::*;
#(
  parameter int DEPTH = NUM_VREGS,
  parameter int WIDTH = VEC_W,
  parameter int IDX_W = $clog2(NUM_VREGS)
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = rd_en ? mem[rd_idx] : rd_data;
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= next_rd_data;
    end
  end
endmodule // sfpcs_vreg_mem

// ==== verilog/sfpcs_top.sv ====
// What this block does
// R01: six low flags stay set until cleared
// R02: flags clear only by load or restore
// R03: six mask bits, set means masked
// R04: reset sets all six mask bits
// R05: write alone never raises an exception
// R06: bits 13-14 select result rounding
// R07: flush-to-zero gives signed zero on underflow
// R08: flush case sets precision and underflow flags
// R09: unmasked underflow ignores flush-to-zero
// R10: reset clears flush-to-zero
// R11: denormals-are-zero zeroes denormal sources, sign kept
// R12: denormals-are-zero suppresses denormal flag and exception
// R13: reset clears denormals-are-zero
// R14: unsupported bit 6 write faults; mask reported
// R15: packed operand is four 32-bit singles
// R16: packed memory operands need 16-byte alignment
// R17: one state shared by all generations
// R18: vector registers independent of legacy registers
// R19: full-state save and restore include this state
// R20: bits 16-31 read zero; nonzero write faults
// R21: flags and masks share one exception order
// R22: rounding 00 nearest, 01 down, 10 up, 11 zero
`timescale 1ns/1ps
module sfpcs_top
  import sfpcs_pkg::*;
#(
  parameter bit DAZ_SUPPORTED = 1'b1,
  parameter int N_VREGS       = NUM_VREGS,
  parameter int VIDX_W        = $clog2(NUM_VREGS)
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  input  wire logic                 ld_valid,
  input  wire logic [CSR_W-1:0]     ld_data,
  input  wire logic                 rstor_valid,
  input  wire logic [CSR_W-1:0]     rstor_data,
  input  wire logic                 save_req,
  input  wire logic                 op_valid,
  input  wire logic [NUM_EXC-1:0]   op_detect,
  input  wire logic [VEC_W-1:0]     op_src,
  input  wire logic [VEC_W-1:0]     op_res,
  input  wire logic [LANES-1:0]     op_res_uflow,
  input  wire logic                 mem_valid,
  input  wire logic [ADDR_W-1:0]    mem_addr,
  input  wire sfpcs_mkind_t         mem_kind,
  input  wire logic                 vreg_wr_en,
  input  wire logic [VIDX_W-1:0]    vreg_wr_idx,
  input  wire logic [VEC_W-1:0]     vreg_wr_data,
  input  wire logic                 vreg_rd_en,
  input  wire logic [VIDX_W-1:0]    vreg_rd_idx,
  output logic      [CSR_W-1:0]     simd_fp_control_status_reg,
  output sfpcs_rc_t                 rounding_control_field,
  output logic                      save_valid,
  output logic      [CSR_W-1:0]     save_csr,
  output logic      [CSR_W-1:0]     supported_bits_mask,
  output logic                      general_protection_fault,
  output logic                      simd_fp_exception,
  output logic                      op_done,
  output logic      [VEC_W-1:0]     op_src_cond,
  output logic      [VEC_W-1:0]     op_res_cond,
  output logic      [VEC_W-1:0]     vreg_rd_data
);
  logic [CSR_W-1:0]   csr;
  logic [CSR_W-1:0]   next_csr;
  logic [CSR_W-1:0]   supp_mask;
  logic               wr_any;
  logic [CSR_W-1:0]   wr_val;
  logic               wr_bad;
  logic               wr_ok;
  logic               mem_bad;
  logic               denormals_are_zero_bit;
  logic               fz;
  logic               um;
  logic [NUM_EXC-1:0] masks;
  logic [NUM_EXC-1:0] det;
  logic [NUM_EXC-1:0] op_set;
  logic               ftz;
  logic               raise;
  logic [LANES-1:0]   src_denorm;
  logic [LANES-1:0]   src_sel;
  logic [LANES-1:0]   res_sel;
  logic [VEC_W-1:0]   src_zeroed;
  logic [VEC_W-1:0]   res_zeroed;
  logic               next_save_valid;
  logic [CSR_W-1:0]   next_save_csr;
  logic               next_gpf;
  logic               next_exc;
  logic               next_op_done;
  logic [VEC_W-1:0]   next_src_cond;
  logic [VEC_W-1:0]   next_res_cond;

  // supported bits, reported on supported_bits_mask every enabled cycle
  always_comb begin
    supp_mask = MASK_FULL;
    if (!DAZ_SUPPORTED) begin
      supp_mask = MASK_FULL & ~DAZ_BIT_VAL; // [R14]
    end
  end

  // control word load and full-state restore decode
  always_comb begin
    wr_any  = ld_valid | rstor_valid; // [R02]
    wr_val  = rstor_valid ? rstor_data : ld_data;
    wr_bad  = wr_any && ((wr_val & ~supp_mask) != '0); // [R14] [R20]
    wr_ok   = wr_any && !wr_bad;
    mem_bad = mem_valid && (mem_kind == MK_PACKED) &&
              (mem_addr[ALIGN_LSB-1:0] != '0); // [R16]
  end

  // mode bits steering the datapath
  always_comb begin
    denormals_are_zero_bit   = csr[DAZ_BIT];
    fz    = csr[FZ_BIT];
    masks = csr[MASK_LO +: NUM_EXC]; // [R03] [R21]
    um    = masks[EXC_UE];
  end

  sfpcs_lane_zero #(
    .N_LANES (LANES)
  ) u_src_zero (
    .data_in  (op_src),
    .zero_sel (src_sel),
    .data_out (src_zeroed),
    .denorm   (src_denorm)
  );

  sfpcs_lane_zero #(
    .N_LANES (LANES)
  ) u_res_zero (
    .data_in  (op_res),
    .zero_sel (res_sel),
    .data_out (res_zeroed),
    .denorm   ()
  );

  // exception detection for one operation
  always_comb begin
    src_sel = {LANES{denormals_are_zero_bit}} & src_denorm; // [R11]
    det     = op_detect;
    det[EXC_DE] = op_detect[EXC_DE] | (|src_denorm);
    if (denormals_are_zero_bit) begin
      det[EXC_DE] = 1'b0; // [R12]
    end
    ftz = fz && um && op_detect[EXC_UE]; // [R07] [R09]
    if (ftz) begin
      det[EXC_PE] = 1'b1; // [R08]
      det[EXC_UE] = 1'b1;
    end
    res_sel = {LANES{op_valid && ftz}} & op_res_uflow; // [R07]
    op_set  = op_valid ? det : '0;
    raise   = op_valid && ((det & ~masks) != '0); // [R05] [R09]
  end

  // register update: hardware set wins over a software clear
  always_comb begin
    next_csr = csr;
    if (wr_ok) begin
      next_csr = wr_val; // [R02] [R17]
    end
    next_csr[FLAG_LO +: NUM_EXC] = next_csr[FLAG_LO +: NUM_EXC] | op_set; // [R01]
    next_csr[RSV_LO +: RSV_W]    = '0; // [R20]
  end

  always_comb begin
    next_save_valid = save_req; // [R19]
    next_save_csr   = save_req ? csr : save_csr;
    next_gpf        = wr_bad || mem_bad; // [R14] [R16]
    next_exc        = raise; // [R05]
    next_op_done    = op_valid;
    next_src_cond   = op_valid ? src_zeroed : op_src_cond; // [R11] [R15]
    next_res_cond   = op_valid ? res_zeroed : op_res_cond; // [R07]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      csr <= CSR_RESET; // [R04] [R10] [R13] [R20]
    end else if (clk_en) begin
      csr <= next_csr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      simd_fp_control_status_reg <= CSR_RESET;
      rounding_control_field     <= RC_NEAREST;
      supported_bits_mask        <= '0;
    end else if (clk_en) begin
      simd_fp_control_status_reg <= next_csr;
      rounding_control_field     <= sfpcs_rc_t'(next_csr[RC_LO +: RC_W]); // [R06] [R22]
      supported_bits_mask        <= supp_mask; // [R14]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      save_valid               <= 1'b0;
      save_csr                 <= '0;
      general_protection_fault <= 1'b0;
      simd_fp_exception        <= 1'b0;
      op_done                  <= 1'b0;
      op_src_cond              <= '0;
      op_res_cond              <= '0;
    end else if (clk_en) begin
      save_valid               <= next_save_valid;
      save_csr                 <= next_save_csr;
      general_protection_fault <= next_gpf;
      simd_fp_exception        <= next_exc;
      op_done                  <= next_op_done;
      op_src_cond              <= next_src_cond;
      op_res_cond              <= next_res_cond;
    end
  end

  // vector registers, private to this unit
  sfpcs_vreg_mem #(
    .DEPTH (N_VREGS),
    .WIDTH (VEC_W),
    .IDX_W (VIDX_W)
  ) u_vregs ( // [R18]
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .wr_en   (vreg_wr_en),
    .wr_idx  (vreg_wr_idx),
    .wr_data (vreg_wr_data),
    .rd_en   (vreg_rd_en),
    .rd_idx  (vreg_rd_idx),
    .rd_data (vreg_rd_data)
  );

  // checks
  chk_flag_sticky: // [R01]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !wr_any) |=>
      ((csr[FLAG_LO +: NUM_EXC] & $past(csr[FLAG_LO +: NUM_EXC]))
        == $past(csr[FLAG_LO +: NUM_EXC])))
  else $error("flag dropped without a write");

  chk_flag_clear_src: // [R02]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok && !op_valid) |=>
      (csr[FLAG_LO +: NUM_EXC] == $past(wr_val[FLAG_LO +: NUM_EXC])))
  else $error("flags not loaded from write data");

  chk_mask_reset: // [R04]
  assert property (@(posedge ref_clk)
    reset |=> (csr[MASK_LO +: NUM_EXC] == '1) && !csr[FZ_BIT] && !csr[DAZ_BIT])
  else $error("reset value of masks or modes wrong");

  chk_no_raise_wr: // [R05]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_any && !op_valid) |=> !simd_fp_exception)
  else $error("exception raised by a register write");

  chk_raise_unmask: // [R03]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && op_detect[EXC_ZE] && !masks[EXC_ZE])
      |=> simd_fp_exception)
  else $error("unmasked exception not raised");

  chk_ftz_flags: // [R08]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && fz && um && op_detect[EXC_UE])
      |=> csr[EXC_PE] && csr[EXC_UE] && op_done)
  else $error("flush case flags missing");

  chk_ftz_zero: // [R07]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && fz && um && op_detect[EXC_UE] && op_res_uflow[0])
      |=> (op_res_cond[LANE_W-2:0] == '0) &&
          (op_res_cond[SIGN_BIT] == $past(op_res[SIGN_BIT])))
  else $error("flushed lane not signed zero");

  chk_ftz_ignored: // [R09]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && !um && op_detect[EXC_UE])
      |=> simd_fp_exception && (op_res_cond == $past(op_res)))
  else $error("unmasked underflow flushed");

  chk_daz_no_de: // [R12]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && denormals_are_zero_bit && !wr_any && !csr[EXC_DE])
      |=> !csr[EXC_DE])
  else $error("denormal flag set under denormals-are-zero");

  chk_rsv_zero: // [R20]
  assert property (@(posedge ref_clk) disable iff (reset)
    (csr[RSV_LO +: RSV_W] == '0) ##1 (simd_fp_control_status_reg == csr))
  else $error("reserved bits nonzero or copy stale");

  chk_gp_hold: // [R14]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_bad && !op_valid) |=>
      general_protection_fault && (csr == $past(csr)))
  else $error("faulting write not refused");

  chk_align: // [R16]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && mem_valid && (mem_kind == MK_PACKED) && (mem_addr[ALIGN_LSB-1:0] != '0))
      |=> general_protection_fault)
  else $error("misaligned packed access not faulted");

  chk_rc_follow: // [R06]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_ok) |=>
      (rounding_control_field == $past(wr_val[RC_LO +: RC_W])))
  else $error("rounding field not following write");
  chk_save_old: // [R19]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && save_req) |=> save_valid && (save_csr == $past(csr)))
  else $error("save did not capture register");
  chk_daz_zero: // [R11]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && denormals_are_zero_bit && src_denorm[0])
      |=> (op_src_cond[LANE_W-2:0] == '0) &&
          (op_src_cond[SIGN_BIT] == $past(op_src[SIGN_BIT])))
  else $error("denormal source lane not signed zero");
  chk_rsv_write: // [R20]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && wr_any && (wr_val[RSV_LO +: RSV_W] != '0)) |=> general_protection_fault)
  else $error("reserved bit write not faulted");
  chk_rc_copy: // [R06]
  assert property (@(posedge ref_clk) disable iff (reset)
    rounding_control_field == simd_fp_control_status_reg[RC_LO +: RC_W])
  else $error("rounding field differs from register");
  chk_src_pass: // [R15]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && op_valid && !denormals_are_zero_bit) |=> (op_src_cond == $past(op_src)))
  else $error("source operand altered without denormals-are-zero");
  chk_op_pulse: // [R05]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !op_valid) |=> !op_done && !simd_fp_exception)
  else $error("op pulse without an op");
  chk_supp_mask: // [R14]
  assert property (@(posedge ref_clk) disable iff (reset)
    clk_en |=> (supported_bits_mask == (DAZ_SUPPORTED ? MASK_FULL : (MASK_FULL & ~DAZ_BIT_VAL))))
  else $error("supported bits mask wrong");
  chk_vreg_quiet: // [R18]
  assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && !vreg_rd_en) |=> (vreg_rd_data == $past(vreg_rd_data)))
  else $error("vector read data changed without a read");
endmodule // sfpcs_top

// ==== dv/sfpcs_tb.sv ====
`timescale 1ns/1ps
module testbench
  import sfpcs_pkg::*;
;
  logic             ref_clk = 1'b0;
  logic             reset, clk_en, ld_valid, rstor_valid, save_req, op_valid, mem_valid;
  logic             vreg_wr_en, vreg_rd_en;
  logic [CSR_W-1:0] ld_data, rstor_data, mem_addr;
  logic [5:0]       op_detect;
  logic [VEC_W-1:0] op_src, op_res, vreg_wr_data;
  logic [3:0]       op_res_uflow;
  logic [2:0]       vreg_wr_idx, vreg_rd_idx;
  sfpcs_mkind_t     mem_kind;
  logic [CSR_W-1:0] simd_fp_control_status_reg, save_csr, supported_bits_mask;
  sfpcs_rc_t        rounding_control_field;
  logic             save_valid, general_protection_fault, simd_fp_exception, op_done;
  logic [VEC_W-1:0] op_src_cond, op_res_cond, vreg_rd_data;
  int               err_count = 0;
  int               num_checks = 0;
  logic [VEC_W-1:0] vd [8];

  sfpcs_top dut_u (
    .ref_clk, .reset, .clk_en, .ld_valid, .ld_data, .rstor_valid, .rstor_data, .save_req,
    .op_valid, .op_detect, .op_src, .op_res, .op_res_uflow, .mem_valid, .mem_addr, .mem_kind,
    .vreg_wr_en, .vreg_wr_idx, .vreg_wr_data, .vreg_rd_en, .vreg_rd_idx,
    .simd_fp_control_status_reg, .rounding_control_field, .save_valid, .save_csr,
    .supported_bits_mask, .general_protection_fault, .simd_fp_exception, .op_done,
    .op_src_cond, .op_res_cond, .vreg_rd_data
  );

  always #10 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick();
    @(negedge ref_clk);
  endtask

  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // rs selects restore instead of load
  task automatic wr(input logic rs, input logic [31:0] d);
    ld_valid = !rs;
    rstor_valid = rs;
    ld_data = d;
    rstor_data = d;
    @(posedge ref_clk);
    ld_valid <= 1'b0;
    rstor_valid <= 1'b0;
    tick();
  endtask

  task automatic op(input logic [5:0] d, input logic [127:0] s, input logic [127:0] r, input logic [3:0] uf);
    op_valid = 1'b1;
    op_detect = d;
    op_src = s;
    op_res = r;
    op_res_uflow = uf;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    tick();
  endtask

  // keep only the sign of the selected lanes
  function automatic logic [127:0] zap(logic [127:0] v, logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      if (sel[i]) v[32*i +: 32] = v[32*i +: 32] & 32'h8000_0000;
    return v;
  endfunction

  initial begin
    repeat (6000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0]  v;
    logic [5:0]   d, e, fl;
    logic [3:0]   uf;
    logic [127:0] s, r, sd;
    reset = 1'b1; clk_en = 1'b1; ld_valid = 1'b0; rstor_valid = 1'b0; save_req = 1'b0;
    op_valid = 1'b0; mem_valid = 1'b0; vreg_wr_en = 1'b0; vreg_rd_en = 1'b0;
    ld_data = '0; rstor_data = '0; mem_addr = '0; op_detect = '0; op_src = '0; op_res = '0;
    op_res_uflow = '0; vreg_wr_idx = '0; vreg_rd_idx = '0; vreg_wr_data = '0; mem_kind = MK_NONE;
    void'($urandom(32'he8ad));
    repeat (8) tick();
    reset = 1'b0;
    chk("csr reset", CSR_RESET, simd_fp_control_status_reg);
    chk("rc reset", 2'b00, rounding_control_field);
    wr(1'b0, 32'h0001_1f80);
    chk("fault rsv ld", 1'b1, general_protection_fault);
    chk("supported", MASK_FULL, supported_bits_mask);
    wr(1'b1, 32'h8000_0000);
    chk("fault rsv rst", 1'b1, general_protection_fault);
    chk("csr kept", CSR_RESET, simd_fp_control_status_reg);
    wr(1'b0, 32'h0000_1f01);
    chk("no exc on write", 1'b0, simd_fp_exception);
    tick();
    chk("no exc later", 1'b0, simd_fp_exception);
    for (int k = 0; k < 6; k++) begin
      v = CSR_RESET & ~(32'h80 << k);
      wr(1'b1, v);
      op(6'h01 << k, {4{32'h3f80_0000}}, '0, 4'h0);
      chk("exc unmasked", 1'b1, simd_fp_exception);
      op(6'h00, {4{32'h3f80_0000}}, '0, 4'h0);
      chk("flag sticky", v | (32'h1 << k), simd_fp_control_status_reg);
      chk("exc none", 1'b0, simd_fp_exception);
    end
    wr(1'b0, CSR_RESET);
    chk("flag cleared", CSR_RESET, simd_fp_control_status_reg);
    wr(1'b0, 32'h0000_9f80);
    r = {$urandom, $urandom, $urandom, $urandom};
    op(6'h10, {4{32'h3f80_0000}}, r, 4'b1010);
    chk("fz result", zap(r, 4'b1010), op_res_cond);
    chk("fz flags", 32'h0000_9fb0, simd_fp_control_status_reg);
    sd = {32'h0000_0000, 32'h007f_ffff, 32'h3f80_0000, 32'h8000_0001};
    wr(1'b0, 32'h0000_1e40);
    op(6'h02, sd, '0, 4'h0);
    chk("daz src", {32'h0, 32'h0, 32'h3f80_0000, 32'h8000_0000}, op_src_cond);
    chk("daz no flag", 32'h0000_1e40, simd_fp_control_status_reg);
    chk("daz no exc", 1'b0, simd_fp_exception);
    wr(1'b0, CSR_RESET);
    op(6'h00, sd, '0, 4'h0);
    chk("denorm flag", CSR_RESET | 32'h2, simd_fp_control_status_reg);
    for (int k = 0; k < 5; k++) begin
      mem_valid = 1'b1;
      mem_kind = sfpcs_mkind_t'(k[1:0]);
      mem_addr = (k == 4) ? 32'h1000_0010 : 32'h1000_0004;
      @(posedge ref_clk);
      mem_valid <= 1'b0;
      tick();
      chk("align fault", k == 0, general_protection_fault);
    end
    wr(1'b0, 32'h0000_3f80);
    save_req = 1'b1;
    wr(1'b0, 32'h0000_5f80);
    save_req = 1'b0;
    chk("save valid", 1'b1, save_valid);
    chk("save old", 32'h0000_3f80, save_csr);
    tick();
    chk("save pulse", 1'b0, save_valid);
    clk_en = 1'b0;
    wr(1'b0, CSR_RESET);
    clk_en = 1'b1;
    chk("frozen", 32'h0000_5f80, simd_fp_control_status_reg);
    for (int i = 0; i < 8; i++) begin
      vd[i] = {$urandom, $urandom, $urandom, $urandom};
      vreg_wr_en = 1'b1;
      vreg_wr_idx = i[2:0];
      vreg_wr_data = vd[i];
      tick();
    end
    vreg_wr_en = 1'b0;
    wr(1'b1, CSR_RESET);
    for (int i = 7; i >= 0; i--) begin
      vreg_rd_en = 1'b1;
      vreg_rd_idx = i[2:0];
      tick();
      chk("vreg read", vd[i], vreg_rd_data);
    end
    vreg_rd_en = 1'b0;
    chk("csr apart", CSR_RESET, simd_fp_control_status_reg);
    for (int n = 0; n < 60; n++) begin
      v = $urandom & MASK_FULL;
      if (v[15]) v[12] = 1'b1;
      wr(1'($urandom), v);
      chk("csr write", v, simd_fp_control_status_reg);
      chk("rc field", v[14:13], rounding_control_field);
      d = 6'($urandom);
      uf = d[4] ? 4'($urandom) : 4'h0;
      s = {$urandom, $urandom, $urandom, $urandom} | {4{32'h0080_0000}};
      r = {$urandom, $urandom, $urandom, $urandom};
      e = d;
      if (v[6]) e[1] = 1'b0;
      fl = v[5:0] | e;
      if (v[15] && v[11] && d[4]) fl[5] = 1'b1;
      op(d, s, r, uf);
      chk("op flags", {v[31:6], fl}, simd_fp_control_status_reg);
      chk("op exc", |(e & ~v[12:7]), simd_fp_exception);
      chk("op done", 1'b1, op_done);
      chk("op src", s, op_src_cond);
      chk("op res", (v[15] && v[11] && d[4]) ? zap(r, uf) : r, op_res_cond);
    end
    // second reset in mid-run with modes and flags set
    wr(1'b0, 32'h0000_e07f);
    reset = 1'b1;
    tick();
    reset = 1'b0;
    chk("csr re-reset", CSR_RESET, simd_fp_control_status_reg);
    chk("rc re-reset", 2'b00, rounding_control_field);
    chk("exc re-reset", 1'b0, simd_fp_exception);
    tally_and_finish();
  end
endmodule // testbench
